//--- src/cps_port_page.sv
// per-port status page with apb slave and port control bits
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
module cps_port_page
  import cps_pkg::*;
#(
  parameter int NP      = CPS_NPORTS,
  parameter int ADDR_W  = 8,
  parameter int CON_DEB = CPS_CON_DEB_CYC,
  parameter int BIAS_DB = CPS_BIAS_DEB_CYC
)(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [2*NP-1:0] pair_a_line,
  input  wire logic [2*NP-1:0] pair_b_line,
  input  wire logic [NP-1:0]   incoming_cable_bias,
  input  wire logic [NP-1:0]   phys_connect,
  input  wire logic [NP-1:0]   dc_link_detected,
  input  wire logic [NP-1:0]   tone_detect,
  input  wire logic [NP-1:0]   signal_valid,
  input  wire logic [NP-1:0]   is_descendant_port,
  input  wire logic [NP-1:0]   beta_mode,
  input  wire logic [NP-1:0]   speed_neg_done,
  input  wire logic [3*NP-1:0] negotiated_rate,
  input  wire logic [NP-1:0]   port_resuming,
  input  wire logic [NP-1:0]   port_suspending,
  input  wire logic [NP-1:0]   standby_active,
  input  wire logic [NP-1:0]   standby_error,
  input  wire logic [NP-1:0]   remote_standby_clr,
  input  wire logic [NP-1:0]   beta_only_cfg,
  output logic      [NP-1:0]   port_off,
  output logic      [NP-1:0]   scrambler_bypass,
  output logic      [NP-1:0]   port_suspend,
  output logic      [NP-1:0]   standby_err_clear,
  output logic                 port_event_flag
);
  localparam int PW = (NP > 1) ? $clog2(NP) : 1;

  ////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_m_r;
  logic rst_sync_b;

  // async assert, release after two edges
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_r    <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_m_r    <= 1'b1;
      rst_sync_b <= rst_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin inputs through two flops
  logic [2*NP-1:0] pa_s;
  logic [2*NP-1:0] pb_s;
  logic [NP-1:0]   bias_s;
  logic [NP-1:0]   conn_s;
  logic [NP-1:0]   dc_s;
  logic [NP-1:0]   tone_s;
  logic [NP-1:0]   sig_s;

  cps_sync #(.W(4*NP)) u_sync_line (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .d          ({pair_a_line, pair_b_line}),
    .q          ({pa_s, pb_s})
  );

  cps_sync #(.W(5*NP)) u_sync_det (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .d          ({incoming_cable_bias, phys_connect, dc_link_detected,
                  tone_detect, signal_valid}),
    .q          ({bias_s, conn_s, dc_s, tone_s, sig_s})
  );

  ////////////////////////////////////////////////////////////////////
  // apb decode
  logic [3:0]    idx;
  logic          addr_ok;
  logic          mapped;
  logic          setup;
  logic          acc;
  logic          wr;
  logic [2:0]    page_sel_r;
  logic [3:0]    port_sel_r;
  logic          port_ok;
  logic          page_ok;
  logic [PW-1:0] sel_idx;
  logic          wr_p0;
  logic          wr_p1;
  logic          wr_sel;
  logic          clr_evt;

  // only the low byte lane carries register data
  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (paddr[ADDR_W-1:6] == '0);
  assign mapped  = addr_ok && ((idx == CPS_IDX_SEL) ||
                   (idx == CPS_IDX_EVT) || idx[3]);
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped && pstrb[0];
  assign port_ok = 32'(port_sel_r) < NP;
  assign page_ok = (page_sel_r == CPS_PAGE_RST) && port_ok;
  assign sel_idx = port_sel_r[PW-1:0];
  assign wr_p0   = wr && page_ok && (idx == CPS_IDX_P0);
  assign wr_p1   = wr && page_ok && (idx == CPS_IDX_P1);
  assign wr_sel  = wr && (idx == CPS_IDX_SEL);
  assign clr_evt = wr && (idx == CPS_IDX_EVT) && pwdata[CPS_EVT_BIT];

  // zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // page and port selection, kept over bus reset
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      page_sel_r <= CPS_PAGE_RST;
      port_sel_r <= CPS_PORT_RST;
    end
    else if (wr_sel)
    begin
      page_sel_r <= pwdata[CPS_PAGE_LSB +: 3];
      port_sel_r <= pwdata[CPS_PORT_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-port state
  logic [NP-1:0] con_w;
  logic [NP-1:0] con_raw;
  logic [NP-1:0] bias_deb;
  logic [NP-1:0] rx_valid;
  logic [NP-1:0] child;
  logic [NP-1:0] irq_en_r;
  logic [NP-1:0] fault_r;
  logic [NP-1:0] fault_set;
  logic [NP-1:0] sb_flt_r;
  logic [NP-1:0] sb_prev_r;
  logic [NP-1:0] sb_clr;
  logic [NP-1:0] evt;
  logic [7:0]    w0 [NP];
  logic [7:0]    w1 [NP];
  logic [7:0]    w2 [NP];

  assign port_suspend = fault_r; // R14

  genvar i;
  generate
    for (i = 0; i < NP; i++)
    begin : g_port
      logic       sel;
      logic       flt_clr;
      logic [2:0] rate_r;
      logic [2:0] rate_in;
      logic [3:0] prev_r;
      logic [3:0] cur;

      assign sel = sel_idx == PW'(i);

      // beta needs tones and a finished speed negotiation
      assign con_raw[i] = beta_mode[i] ?
                          (tone_s[i] && speed_neg_done[i]) :
                          conn_s[i]; // R7

      cps_debounce #(.CYC(CON_DEB)) u_con_deb (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .raw        (con_raw[i]),
        .stable     (con_w[i])
      ); // R5 R6

      cps_debounce #(.CYC(BIAS_DB)) u_bias_deb (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .raw        (bias_s[i]),
        .stable     (bias_deb[i])
      );

      // tones alone never raise this in beta mode
      assign rx_valid[i] = beta_mode[i] ? sig_s[i] : bias_deb[i]; // R8 R9

      // anything not plainly attached reports as child
      assign child[i] = is_descendant_port[i] || !con_w[i] ||
                        port_off[i] || fault_r[i]; // R3

      // resume without bias, or suspend with bias, is a fault
      assign fault_set[i] = (port_resuming[i] && !bias_deb[i]) ||
                            (port_suspending[i] && bias_deb[i]); // R15
      assign flt_clr = wr_p1 && sel && pwdata[CPS_FLT_BIT];

      // standby fault leaves on write, remote command or standby exit
      assign sb_clr[i] = (wr_p1 && sel && pwdata[CPS_SBF_BIT]) ||
                         remote_standby_clr[i] ||
                         (sb_prev_r[i] && !standby_active[i]); // R17 R18

      // reserved rate codes are not taken
      assign rate_in = negotiated_rate[3*i +: 3];
      assign cur = {con_w[i], bias_deb[i], port_off[i], fault_r[i]};
      assign evt[i] = irq_en_r[i] && (cur != prev_r); // R23 R13

      // controls change only on port writes; hardware reset clears them
      always_ff @(posedge sys_clk or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
        begin
          port_off[i]         <= CPS_CTRL_RST;
          irq_en_r[i]         <= CPS_CTRL_RST;
          scrambler_bypass[i] <= CPS_CTRL_RST;
        end
        else
        begin
          if (wr_p0 && sel)
            port_off[i] <= pwdata[CPS_DIS_BIT]; // R10 R11
          if (wr_p1 && sel)
          begin
            irq_en_r[i]         <= pwdata[CPS_IEN_BIT]; // R13
            scrambler_bypass[i] <= pwdata[CPS_SCR_BIT]; // R19
          end
        end
      end

      // sticky flags: a set in the clear cycle wins
      always_ff @(posedge sys_clk or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
        begin
          fault_r[i]           <= CPS_CTRL_RST;
          sb_flt_r[i]          <= CPS_CTRL_RST;
          sb_prev_r[i]         <= CPS_CTRL_RST;
          standby_err_clear[i] <= CPS_CTRL_RST;
          rate_r               <= CPS_RATE_RST;
          prev_r               <= 4'h0;
        end
        else
        begin
          fault_r[i] <= fault_set[i] ||
                        (fault_r[i] && !flt_clr); // R14 R16
          sb_flt_r[i] <= standby_error[i] ||
                         (sb_flt_r[i] && !sb_clr[i]); // R17
          sb_prev_r[i] <= standby_active[i];
          standby_err_clear[i] <= sb_clr[i]; // R18
          if (rate_in <= CPS_S3200)
            rate_r <= rate_in; // R12 R22
          prev_r <= cur;
        end
      end

      a_standby_exit: assert property ( // R17
        @(posedge sys_clk) disable iff (!rst_sync_b)
        ($fell(standby_active[i]) && !standby_error[i]) |=> !sb_flt_r[i])
        else $error("standby fault kept after standby exit");

      // page words for this port
      assign w0[i] = {pa_s[2*i +: 2], pb_s[2*i +: 2], child[i],
                      con_w[i], rx_valid[i], port_off[i]}; // R1 R2
      assign w1[i] = {rate_r, irq_en_r[i], fault_r[i], sb_flt_r[i],
                      scrambler_bypass[i], beta_only_cfg[i]}; // R20
      assign w2[i] = {dc_s[i], 7'h00}; // R21
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // global port event flag, write 1 to clear
  logic evt_any;

  assign evt_any = |evt;

  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      port_event_flag <= CPS_CTRL_RST;
    else
      port_event_flag <= evt_any ||
                         (port_event_flag && !clr_evt); // R23
  end

  ////////////////////////////////////////////////////////////////////
  // read path, captured in the setup cycle
  logic [7:0] page_word;
  logic [7:0] rd_word;

  // wrong page or absent port reads as zero
  assign page_word = !page_ok ? 8'h00 :
                     (idx == CPS_IDX_P0) ? w0[sel_idx] :
                     (idx == CPS_IDX_P1) ? w1[sel_idx] :
                     (idx == CPS_IDX_P2) ? w2[sel_idx] :
                     8'h00; // R24
  assign rd_word = !mapped ? 8'h00 :
                   (idx == CPS_IDX_SEL) ?
                     {page_sel_r, 1'b0, port_sel_r} :
                   (idx == CPS_IDX_EVT) ?
                     {7'h00, port_event_flag} :
                   page_word;

  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= {24'h000000, rd_word};
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  logic rd_p0;
  assign rd_p0 = setup && !pwrite && mapped && page_ok &&
                 (idx == CPS_IDX_P0);

  a_pair_a_read: assert property ( // R1
    rd_p0 |=> prdata[7:6] == $past(pa_s[2*sel_idx +: 2]))
    else $error("pair a state misread");

  a_unimpl_zero: assert property ( // R24
    (setup && !pwrite && idx[3] && !port_ok) |=> prdata == 32'h0)
    else $error("absent port read not zero");

  a_off_child: assert property ( // R3
    port_off[0] |-> (rd_p0 && sel_idx == '0 |=> prdata[CPS_DESC_BIT]))
    else $error("off port not reported as child");

  a_con_stable: assert property ( // R5
    $rose(con_w[0]) |-> $past(con_raw[0]) && $past(con_raw[0], 2))
    else $error("connection flag rose without stable input");

  a_off_write: assert property ( // R10
    (wr_p0 && sel_idx == '0) |=> port_off[0] == $past(pwdata[0]))
    else $error("port off write lost");

  a_fault_set: assert property ( // R15
    (port_resuming[0] && !bias_deb[0]) |=> fault_r[0] ##1 fault_r[0]
      or (fault_r[0] ##1 1'b1))
    else $error("resume fault not flagged");

  a_fault_hold: assert property ( // R16
    (fault_r[0] && !(wr_p1 && pwdata[CPS_FLT_BIT])) |=> fault_r[0])
    else $error("fault flag dropped without a clear");

  a_event_flag: assert property ( // R23
    evt_any |=> port_event_flag)
    else $error("port event not flagged");
endmodule // cps_port_page

//--- src/cps_pkg.sv
// constants and field layout of the per-port status page
// Behaviour
// R1 - pair-A line state of selected port read as 11 Z, 01 one, 10 zero
// R2 - pair-B line state read in its own field with the same codes
// R3 - role reads 1 child, 0 parent; off, unconnected or suspended reads child
// R4 - software ignores the role bit from bus reset until tree id ends
// R5 - connection flag sets only after about 341 ms of stable connection
// R6 - connection flag clears on hardware reset, kept over bus reset
// R7 - beta links: connected needs peer tones plus finished speed negotiation
// R8 - receive valid: debounced bias in legacy mode, valid signal in beta
// R9 - beta mode with only tones seen keeps receive valid low
// R10 - port-off bit disables port, resets to 0, kept over bus reset
// R11 - an off port still tones but never completes an active connection
// R12 - 3-bit agreed rate read-only, from the port's negotiation source
// R13 - event enable lets a port event set the global flag and notify link
// R14 - resume or suspend fault sets the fault flag, port then suspended
// R15 - resume fault: no bias while resuming; suspend fault: bias while suspending
// R16 - fault flag cleared by writing 1 or hardware reset, kept over bus reset
// R17 - standby fault sets on standby error, clears on leaving standby
// R18 - writing 1 or remote command clears standby fault and standby errors
// R19 - scrambler bypass bit sends packet data unscrambled on that port
// R20 - beta-only bit reads 1 for a beta-only port, else 0
// R21 - dc link bit reads 1 when the legacy detector senses dc connection
// R22 - rate code 000..101 is S100..S3200, 110 and 111 reserved
// R23 - change of con, bias, off or fault on enabled port sets flag; W1C
// R24 - unimplemented port selection reads every page register as 0
package cps_pkg;
  localparam int CPS_NPORTS = 3;
  localparam int CPS_CLK_KHZ = 125000;
  localparam int CPS_CON_DEB_MS = 341;
  // ms times kHz gives cycles
  localparam int CPS_CON_DEB_CYC = CPS_CON_DEB_MS * CPS_CLK_KHZ;
  localparam int CPS_BIAS_DEB_CYC = 16;
  // register indices; byte address is four times the index
  localparam logic [3:0] CPS_IDX_EVT = 4'h5;
  localparam logic [3:0] CPS_IDX_SEL = 4'h7;
  localparam logic [3:0] CPS_IDX_P0 = 4'h8;
  localparam logic [3:0] CPS_IDX_P1 = 4'h9;
  localparam logic [3:0] CPS_IDX_P2 = 4'hA;
  // field positions, bit 7 is the leftmost bit of each byte
  localparam int CPS_A_LSB = 6;
  localparam int CPS_B_LSB = 4;
  localparam int CPS_DESC_BIT = 3;
  localparam int CPS_CON_BIT = 2;
  localparam int CPS_RXV_BIT = 1;
  localparam int CPS_DIS_BIT = 0;
  localparam int CPS_NEG_LSB = 5;
  localparam int CPS_IEN_BIT = 4;
  localparam int CPS_FLT_BIT = 3;
  localparam int CPS_SBF_BIT = 2;
  localparam int CPS_SCR_BIT = 1;
  localparam int CPS_BONLY_BIT = 0;
  localparam int CPS_DC_BIT = 7;
  localparam int CPS_PAGE_LSB = 5;
  localparam int CPS_PORT_LSB = 0;
  localparam int CPS_EVT_BIT = 0;
  // line state codes
  localparam logic [1:0] CPS_LINE_Z = 2'h3;
  localparam logic [1:0] CPS_LINE_ONE = 2'h1;
  localparam logic [1:0] CPS_LINE_ZERO = 2'h2;
  localparam logic [1:0] CPS_LINE_BAD = 2'h0;
  // rate codes
  localparam logic [2:0] CPS_S100 = 3'h0;
  localparam logic [2:0] CPS_S3200 = 3'h5;
  // reset values
  localparam logic [2:0] CPS_PAGE_RST = 3'h0;
  localparam logic [3:0] CPS_PORT_RST = 4'h0;
  localparam logic CPS_CTRL_RST = 1'b0;
  localparam logic [2:0] CPS_RATE_RST = CPS_S100;
endpackage

//--- src/cps_sync.sv
// two-stage synchroniser for pin-level inputs
`timescale 1ns/100ps
module cps_sync
  import cps_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         sys_clk,
  input  wire logic         rst_sync_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // cps_sync

//--- src/cps_debounce.sv
// stability filter: output rises after CYC stable high cycles
`timescale 1ns/100ps
module cps_debounce
  import cps_pkg::*;
#(
  parameter int CYC = 16
)(
  input  wire logic sys_clk,
  input  wire logic rst_sync_b,
  input  wire logic raw,
  output logic      stable
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt_r;

  // any low sample restarts the wait; loss is reported at once
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cnt_r  <= '0;
      stable <= 1'b0;
    end
    else if (!raw)
    begin
      cnt_r  <= '0;
      stable <= 1'b0;
    end
    else if (cnt_r == LAST)
      stable <= 1'b1;
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule // cps_debounce

//--- tb/cps_peer_phy.sv
// behavioural peer phy seen across the three cable ports
`timescale 1ns/100ps
module cps_peer_phy
  import cps_pkg::*;
#(
  parameter int NP = CPS_NPORTS
)(
  input  wire logic            sys_clk,
  input  wire logic [NP-1:0]   plugged,
  input  wire logic [NP-1:0]   beta,
  input  wire logic [NP-1:0]   bias_on,
  input  wire logic [NP-1:0]   sig_on,
  input  wire logic [2*NP-1:0] a_req,
  input  wire logic [2*NP-1:0] b_req,
  output logic      [2*NP-1:0] pair_a_line,
  output logic      [2*NP-1:0] pair_b_line,
  output logic      [NP-1:0]   incoming_cable_bias,
  output logic      [NP-1:0]   phys_connect,
  output logic      [NP-1:0]   dc_link_detected,
  output logic      [NP-1:0]   tone_detect,
  output logic      [NP-1:0]   signal_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // pins move just after an edge; an unplugged pair floats to Z code
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NP; i++)
    begin
      pair_a_line[2*i+:2]    <= plugged[i] ? a_req[2*i+:2] : CPS_LINE_Z;
      pair_b_line[2*i+:2]    <= plugged[i] ? b_req[2*i+:2] : CPS_LINE_Z;
      incoming_cable_bias[i] <= plugged[i] & bias_on[i];
      // legacy cables show dc contact, beta ones tones and, with sig_on, a valid signal
      phys_connect[i]        <= plugged[i] & ~beta[i];
      dc_link_detected[i]    <= plugged[i] & ~beta[i];
      tone_detect[i]         <= plugged[i] & beta[i];
      signal_valid[i]        <= plugged[i] & beta[i] & sig_on[i];
    end
  end
endmodule // cps_peer_phy

//--- tb/cps_port_page_test.sv
// self-checking bench for the per-port status page
`timescale 1ns/100ps
module cps_port_page_test
  import cps_pkg::*;
;
  localparam int NP  = 3;
  localparam int TMO = 50;
  logic            sys_clk = 1'b0;
  logic            rst_b   = 1'b0;
  logic [7:0]      paddr;
  logic            psel, penable, pwrite;
  logic [31:0]     pwdata;
  logic [3:0]      pstrb;
  logic [31:0]     prdata;
  logic            pready, pslverr, port_event_flag;
  logic [2*NP-1:0] pair_a_line, pair_b_line, a_req, b_req;
  logic [NP-1:0]   bias, pcon, dcl, tone, sval, desc, bmode, negd;
  logic [NP-1:0]   resm, susp, sb_act, sb_err, sb_rclr, bonly;
  logic [NP-1:0]   plugged, bias_on, sig_on;
  logic [3*NP-1:0] rate;
  logic [NP-1:0]   port_off, scrambler_bypass, port_suspend, sb_clr;
  int              errors, n_checks;

  always #4 sys_clk = ~sys_clk;

  cps_port_page #(.CON_DEB(20), .BIAS_DB(4)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pair_a_line(pair_a_line), .pair_b_line(pair_b_line),
    .incoming_cable_bias(bias), .phys_connect(pcon),
    .dc_link_detected(dcl), .tone_detect(tone), .signal_valid(sval),
    .is_descendant_port(desc), .beta_mode(bmode), .speed_neg_done(negd),
    .negotiated_rate(rate), .port_resuming(resm), .port_suspending(susp),
    .standby_active(sb_act), .standby_error(sb_err),
    .remote_standby_clr(sb_rclr), .beta_only_cfg(bonly),
    .port_off(port_off), .scrambler_bypass(scrambler_bypass),
    .port_suspend(port_suspend), .standby_err_clear(sb_clr),
    .port_event_flag(port_event_flag));

  cps_peer_phy #(.NP(NP)) peer (
    .sys_clk(sys_clk), .plugged(plugged), .beta(bmode), .bias_on(bias_on),
    .sig_on(sig_on), .a_req(a_req), .b_req(b_req),
    .pair_a_line(pair_a_line), .pair_b_line(pair_b_line),
    .incoming_cable_bias(bias), .phys_connect(pcon),
    .dc_link_detected(dcl), .tone_detect(tone), .signal_valid(sval));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one apb transfer, entered just after an edge; one idle cycle after
  task automatic apb(input logic w, input logic [3:0] idx,
                     input logic [7:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < TMO);
    if (pready !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] m,
                       input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 8'h00, q, e);
    chk(q & {24'h0, m}, {24'h0, exp});
  endtask

  task automatic sel(input logic [3:0] p);
    wr(CPS_IDX_SEL, {CPS_PAGE_RST, 1'b0, p});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(CPS_IDX_EVT, 8'hFF, 8'h00);
    rdchk(CPS_IDX_SEL, 8'hFF, 8'h00);
    rdchk(CPS_IDX_P0, 8'hFF, 8'hF8);
    rdchk(CPS_IDX_P1, 8'hFF, 8'h00);
    rdchk(CPS_IDX_P2, 8'hFF, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_lines;
    sel(4'h1);
    plugged[1] <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      a_req[3:2] <= c[1:0];
      b_req[3:2] <= ~c[1:0];
      idle(4);
      rdchk(CPS_IDX_P0, 8'hF0, {c[1:0], ~c[1:0], 4'h0});
    end
    plugged[1] <= 1'b0;
    $display("test lines done");
  endtask

  task automatic t_connect;
    sel(4'h0);
    wr(CPS_IDX_P1, 8'h10);
    a_req[1:0] <= CPS_LINE_ONE;
    b_req[1:0] <= CPS_LINE_ZERO;
    bias_on[0] <= 1'b1;
    plugged[0] <= 1'b1;
    idle(10);
    rdchk(CPS_IDX_P0, 8'h04, 8'h00);
    idle(30);
    // role bit read only once the tree has settled
    rdchk(CPS_IDX_P0, 8'hFF, 8'h66);
    desc[0] <= 1'b1;
    rdchk(CPS_IDX_P0, 8'h08, 8'h08);
    desc[0] <= 1'b0;
    rdchk(CPS_IDX_P2, 8'h80, 8'h80);
    rdchk(CPS_IDX_EVT, 8'h01, 8'h01);
    wr(CPS_IDX_EVT, 8'h01);
    rdchk(CPS_IDX_EVT, 8'h01, 8'h00);
    $display("test connect done");
  endtask

  task automatic t_ctrl;
    wr(CPS_IDX_P0, 8'h01);
    idle(3);
    chk(port_off, 3'h1);
    chk(port_event_flag, 1'b1);
    rdchk(CPS_IDX_P0, 8'h01, 8'h01);
    wr(CPS_IDX_P0, 8'h00);
    wr(CPS_IDX_P1, 8'h12);
    chk(scrambler_bypass, 3'h1);
    rdchk(CPS_IDX_P1, 8'h12, 8'h12);
    wr(CPS_IDX_P1, 8'h10);
    chk({port_off, scrambler_bypass}, 6'h00);
    wr(CPS_IDX_EVT, 8'h01);
    $display("test control done");
  endtask

  task automatic t_fault;
    susp[0] <= 1'b1;
    idle(4);
    chk(port_suspend, 3'h1);
    rdchk(CPS_IDX_P1, 8'h08, 8'h08);
    rdchk(CPS_IDX_P0, 8'h08, 8'h08);
    susp[0] <= 1'b0;
    wr(CPS_IDX_P1, 8'h18);
    rdchk(CPS_IDX_P1, 8'h08, 8'h00);
    bias_on[0] <= 1'b0;
    idle(8);
    resm[0] <= 1'b1;
    idle(4);
    chk(port_suspend, 3'h1);
    resm[0] <= 1'b0;
    wr(CPS_IDX_P1, 8'h18);
    chk(port_suspend, 3'h0);
    bias_on[0] <= 1'b1;
    $display("test fault done");
  endtask

  task automatic t_standby;
    logic seen;
    sel(4'h1);
    for (int k = 0; k < 3; k++)
    begin
      seen = 1'b0;
      sb_act[1] <= 1'b1;
      sb_err[1] <= 1'b1;
      idle(1);
      sb_err[1] <= 1'b0;
      idle(2);
      rdchk(CPS_IDX_P1, 8'h04, 8'h04);
      if (k == 0)
        wr(CPS_IDX_P1, 8'h04);
      if (k == 1)
        sb_rclr[1] <= 1'b1;
      if (k == 2)
        sb_act[1] <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        @(posedge sys_clk);
        sb_rclr[1] <= 1'b0;
        seen = seen | sb_clr[1];
      end
      if (k == 1)
        chk(seen, 1'b1);
      rdchk(CPS_IDX_P1, 8'h04, 8'h00);
    end
    $display("test standby done");
  endtask

  task automatic t_rate;
    bonly[1] <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      rate[5:3] <= r[2:0];
      idle(3);
      // reserved codes leave the last good rate in place
      rdchk(CPS_IDX_P1, 8'hE1,
            {(r > 5) ? CPS_S3200 : r[2:0], 5'h01});
    end
    $display("test rate done");
  endtask

  task automatic t_beta;
    sel(4'h2);
    bmode[2]   <= 1'b1;
    bias_on[2] <= 1'b1;
    plugged[2] <= 1'b1;
    idle(40);
    rdchk(CPS_IDX_P0, 8'h06, 8'h00);
    negd[2] <= 1'b1;
    idle(40);
    rdchk(CPS_IDX_P0, 8'h06, 8'h04);
    sig_on[2] <= 1'b1;
    idle(4);
    rdchk(CPS_IDX_P0, 8'h06, 8'h06);
    $display("test beta done");
  endtask

  task automatic t_unimpl;
    logic [31:0] q;
    logic        e;
    // a write without the low byte lane must be ignored
    pstrb <= 4'hE;
    wr(CPS_IDX_P0, 8'h01);
    pstrb <= 4'hF;
    chk(port_off, 3'h0);
    sel(4'h3);
    rdchk(CPS_IDX_P0, 8'hFF, 8'h00);
    rdchk(CPS_IDX_P1, 8'hFF, 8'h00);
    rdchk(CPS_IDX_P2, 8'hFF, 8'h00);
    wr(CPS_IDX_P0, 8'h01);
    chk(port_off, 3'h0);
    apb(1'b0, 4'h0, 8'h00, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test unimplemented done");
  endtask

  // mid-run hardware reset clears controls and the debounced flag
  task automatic t_hwreset;
    sel(4'h0);
    wr(CPS_IDX_P0, 8'h01);
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    idle(3);
    rdchk(CPS_IDX_SEL, 8'hFF, 8'h00);
    rdchk(CPS_IDX_P0, 8'h05, 8'h00);
    rdchk(CPS_IDX_P1, 8'h18, 8'h00);
    rdchk(CPS_IDX_EVT, 8'h01, 8'h00);
    idle(30);
    rdchk(CPS_IDX_P0, 8'h04, 8'h04);
    $display("test hardware reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    n_checks = 0;
    {paddr, psel, penable, pwrite, pwdata} <= '0;
    pstrb <= 4'hF;
    {a_req, b_req, desc, bmode, negd, rate, resm, susp} <= '0;
    {sb_act, sb_err, sb_rclr, bonly, plugged, bias_on, sig_on} <= '0;
    idle(10);
    rst_b <= 1'b1;
    idle(5);
    t_reset();
    t_lines();
    t_connect();
    t_ctrl();
    t_fault();
    t_standby();
    t_rate();
    t_beta();
    t_unimpl();
    t_hwreset();
    tally_and_finish();
  end
endmodule // cps_port_page_test
